// ===== src/wpx_bus_if.sv
// open-drain two-wire bus joining the controller and the wiper slave
`timescale 1ns/1ps
interface wpx_bus_if;
  logic scl_o;
  logic scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // a line is low when any party enables a low driver, else pulled up
  assign scl = ~(~scl_oe_n & ~scl_o);
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));

  modport master (output scl_o, output scl_oe_n, output m_sda_o, output m_sda_oe_n,
                  input scl, input sda);
  modport slave  (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface : wpx_bus_if

// ===== src/wpx_master.sv
// two-wire bus controller for the wiper slave, driven from apb registers
`timescale 1ns/1ps
module wpx_master (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  wpx_bus_if.master        bus,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  // software registers
  logic [6:0]                 cmd_id;
  logic                       cmd_rd;
  logic [3:0]                 cmd_cnt;
  logic [7:0]                 addr_b;
  logic [7:0]                 data_b;
  logic [7:0]                 rdata;
  logic                       busy;
  logic                       nack;

  // bit engine
  logic [1:0]                 sda_sync;
  logic [7:0]                 qcnt;
  logic [1:0]                 phase;
  logic [3:0]                 bcnt;
  logic [7:0]                 shb;
  logic [3:0]                 rleft;
  logic                       ack_n;
  logic                       scl_oe_n;
  logic                       sda_oe_n;
  logic                       pad_lo;
  wpx_pkg::wpx_mst_state_t    state;
  wpx_pkg::wpx_step_t         step;

  // decode
  logic                       sda_s;
  logic                       tick;
  logic                       ninth;
  logic                       access;
  logic                       wr_done;
  logic                       sel_cmd;
  logic                       sel_txd;
  logic                       sel_stat;
  logic                       mapped;
  logic                       launch;
  logic                       next_sda_oe_n;
  logic [31:0]                rd_word;

  assign sda_s = sda_sync[1];
  assign tick  = (qcnt == wpx_pkg::QTR_LAST);
  assign ninth = (bcnt == wpx_pkg::BYTE_BITS);

  // apb decode; the answer comes one cycle into the access phase
  assign access   = psel_i & penable_i & ~pready_o;
  assign wr_done  = psel_i & penable_i & pready_o & pwrite_i;
  assign sel_cmd  = (paddr_i == wpx_pkg::REG_CMD);
  assign sel_txd  = (paddr_i == wpx_pkg::REG_TXD);
  assign sel_stat = (paddr_i == wpx_pkg::REG_STAT);
  assign mapped   = sel_cmd | sel_txd | sel_stat;
  assign launch   = wr_done & sel_cmd & pwdata_i[wpx_pkg::CMD_GO] & ~busy;

  assign rd_word = sel_cmd  ? {17'h00000, cmd_id, cmd_cnt, 2'b00, cmd_rd, busy} :
                   sel_txd  ? {16'h0000, data_b, addr_b} :
                   sel_stat ? {16'h0000, rdata, 6'h00, nack, busy} : 32'h00000000;

  // level put on the data line in the low quarter of each symbol
  assign next_sda_oe_n = (state == wpx_pkg::mst_start) ? 1'b1 :
                         (state == wpx_pkg::mst_stop)  ? 1'b0 :
                         (state == wpx_pkg::mst_tx)    ? (ninth | shb[7]) :
                         (ninth ? (rleft == 4'h0) : 1'b1);

  // open-drain pads: only the enables move
  assign bus.scl_o      = pad_lo;
  assign bus.m_sda_o    = pad_lo;
  assign bus.scl_oe_n   = scl_oe_n;
  assign bus.m_sda_oe_n = sda_oe_n;

  // apb answer; writes act at the edge where pready is seen high
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
      pad_lo    <= 1'b0;
    end else begin
      pready_o  <= access;
      pslverr_o <= access & ~mapped;
      prdata_o  <= (access & ~pwrite_i) ? rd_word : 32'h00000000;
      pad_lo    <= 1'b0;
    end
  end

  // transmit register; command fields are latched only when a transfer starts
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_b  <= 8'h00;
      data_b  <= 8'h00;
      cmd_id  <= 7'h00;
      cmd_rd  <= 1'b0;
      cmd_cnt <= 4'h0;
    end else if (wr_done && sel_txd) begin
      addr_b <= pwdata_i[wpx_pkg::TXD_ADDR_LSB +: 8];
      data_b <= pwdata_i[wpx_pkg::TXD_DATA_LSB +: 8];
    end else if (launch) begin
      cmd_id  <= pwdata_i[wpx_pkg::CMD_ID_LSB +: 7];
      cmd_rd  <= pwdata_i[wpx_pkg::CMD_READ];
      cmd_cnt <= pwdata_i[wpx_pkg::CMD_CNT_LSB +: 4];
    end
  end

  // the read-back line is sampled through two flops before use
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end

  // symbol engine: quarter 0 clock low and data set, 1 clock high,
  // 2 sample or start/stop edge, 3 clock low again except in a stop, where it stays released
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= wpx_pkg::mst_idle;
      step     <= wpx_pkg::step_idw;
      qcnt     <= 8'h00;
      phase    <= 2'b00;
      bcnt     <= 4'h0;
      shb      <= 8'h00;
      rleft    <= 4'h0;
      ack_n    <= 1'b1;
      rdata    <= 8'h00;
      busy     <= 1'b0;
      nack     <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (launch) begin
      // the controller alone starts a transfer and owns the clock
      state <= wpx_pkg::mst_start;
      step  <= wpx_pkg::step_idw;
      busy  <= 1'b1;
      nack  <= 1'b0;
      qcnt  <= 8'h00;
      phase <= 2'b00;
      rleft <= (pwdata_i[wpx_pkg::CMD_CNT_LSB +: 4] == 4'h0) ? 4'h0 :
               pwdata_i[wpx_pkg::CMD_CNT_LSB +: 4] - 4'h1;
    end else if (state != wpx_pkg::mst_idle) begin
      qcnt <= tick ? 8'h00 : qcnt + 8'h01;
      if (tick) begin
        phase <= phase + 2'b01;
        unique case (phase)
          2'b00: begin
            scl_oe_n <= 1'b0;
            sda_oe_n <= next_sda_oe_n;
          end
          2'b01: begin
            scl_oe_n <= 1'b1;
          end
          2'b10: begin
            if (state == wpx_pkg::mst_start) begin
              sda_oe_n <= 1'b0;
            end else if (state == wpx_pkg::mst_stop) begin
              sda_oe_n <= 1'b1;
            end else if (state == wpx_pkg::mst_tx && ninth) begin
              ack_n <= sda_s;
            end else if (state == wpx_pkg::mst_rx && !ninth) begin
              shb <= {shb[6:0], sda_s};
            end
          end
          2'b11: begin
            scl_oe_n <= (state == wpx_pkg::mst_stop);
            if (state == wpx_pkg::mst_stop) begin
              state <= wpx_pkg::mst_idle;
              busy  <= 1'b0;
            end else if (state == wpx_pkg::mst_start) begin
              // a start after the address byte is the repeated start of a read
              state <= wpx_pkg::mst_tx;
              bcnt  <= 4'h0;
              shb   <= {cmd_id, step == wpx_pkg::step_addr};
              step  <= (step == wpx_pkg::step_addr) ? wpx_pkg::step_idr : wpx_pkg::step_idw;
            end else if (!ninth) begin
              bcnt <= bcnt + 4'h1;
              if (state == wpx_pkg::mst_tx) begin
                shb <= {shb[6:0], 1'b0};
              end
            end else if (state == wpx_pkg::mst_rx) begin
              rdata <= shb;
              bcnt  <= 4'h0;
              if (rleft == 4'h0) begin
                state <= wpx_pkg::mst_stop;
              end else begin
                rleft <= rleft - 4'h1;
              end
            end else if (ack_n) begin
              nack  <= 1'b1;
              state <= wpx_pkg::mst_stop;
            end else begin
              bcnt <= 4'h0;
              unique case (step)
                wpx_pkg::step_idw: begin
                  shb  <= addr_b;
                  step <= wpx_pkg::step_addr;
                end
                wpx_pkg::step_addr: begin
                  if (cmd_rd) begin
                    state <= wpx_pkg::mst_start;
                  end else begin
                    shb  <= data_b;
                    step <= wpx_pkg::step_data;
                  end
                end
                wpx_pkg::step_data: begin
                  state <= wpx_pkg::mst_stop;
                end
                wpx_pkg::step_idr: begin
                  state <= wpx_pkg::mst_rx;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

endmodule : wpx_master

// ===== src/wpx_pkg.sv
// shared constants and types for the wiper position serial link
package wpx_pkg;
  // system clock and serial bit rate; the controller splits each bit into four quarters
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned SCL_HZ   = 100_000;
  localparam int unsigned QTR_CYC  = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0]  QTR_LAST = 8'(QTR_CYC - 1);
  // start conditions are ignored for this many cycles after power-up
  localparam logic [3:0]  PWRUP_CYC   = 4'h8;
  // device code carried in the upper seven bits of the identification byte; value is arbitrary
  localparam logic [6:0]  SLAVE_ID    = 7'h2a;
  localparam logic [6:0]  WIPER_RESET = 7'h40;
  localparam logic [7:0]  WIPER_ADDR  = 8'h00;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  LAST_BIT    = 4'h7;
  // controller register map, byte addresses
  localparam logic [7:0]  REG_CMD     = 8'h00;
  localparam logic [7:0]  REG_TXD     = 8'h04;
  localparam logic [7:0]  REG_STAT    = 8'h08;
  // command fields
  localparam int          CMD_GO      = 0;
  localparam int          CMD_READ    = 1;
  localparam int          CMD_CNT_LSB = 4;
  localparam int          CMD_ID_LSB  = 8;
  // transmit fields
  localparam int          TXD_ADDR_LSB = 0;
  localparam int          TXD_DATA_LSB = 8;

  typedef enum logic [2:0] {
    dev_idle = 3'b000,
    dev_recv = 3'b001,
    dev_ack  = 3'b010,
    dev_send = 3'b011,
    dev_mack = 3'b100
  } wpx_dev_state_t;

  // what the device expects after the current acknowledge
  typedef enum logic [2:0] {
    kind_id   = 3'b000,
    kind_addr = 3'b001,
    kind_data = 3'b010,
    kind_send = 3'b011,
    kind_done = 3'b100
  } wpx_kind_t;

  typedef enum logic [2:0] {
    mst_idle  = 3'b000,
    mst_start = 3'b001,
    mst_tx    = 3'b010,
    mst_rx    = 3'b011,
    mst_stop  = 3'b100
  } wpx_mst_state_t;

  // last byte the controller has sent
  typedef enum logic [1:0] {
    step_idw  = 2'b00,
    step_addr = 2'b01,
    step_data = 2'b10,
    step_idr  = 2'b11
  } wpx_step_t;
endpackage : wpx_pkg

// ===== src/wpx_slave.sv
// wiper position slave: serial byte decode and the volatile wiper register
`timescale 1ns/1ps

// Summary of operation
// - seven-bit volatile register alone selects wiper tap
// - zero puts wiper nearest low terminal
// - all ones nearest high; rising values move monotonically
// - power-up presets wiper register to midscale
// - device is slave; master clocks everything
// - bytes travel most significant bit first
// - data changes only while clock low
// - data line released after power-up
// - wait for start; ignore starts during power-up
// - master ends each operation with stop
// - sender releases after eight; receiver acks ninth
// - ack valid id, address and write data
// - id holds device code plus direction bit
// - write is id, address, data, then standby
// - data loads wiper on last bit's falling edge
// - no ack for wrong id or address
// - read: id, address, repeated start, read id
// - keep sending while master acknowledges each byte
// - master acknowledges received read bytes
// - master stops after last wanted byte
// - wiper register writable and readable over bus
module wpx_slave (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  wpx_bus_if.slave        bus,
  output logic [6:0]      wiper_position_o
);

  // synchronisers and a third stage for edge detection
  logic [1:0]                 scl_sync;
  logic [1:0]                 sda_sync;
  logic                       scl_q;
  logic                       sda_q;

  // power-up holdoff
  logic [3:0]                 pwr_cnt;

  // byte engine
  wpx_pkg::wpx_dev_state_t    state;
  wpx_pkg::wpx_kind_t         kind;
  logic [3:0]                 cnt;
  logic [7:0]                 rx_shift;
  logic [7:0]                 tx_shift;
  logic                       mack;
  logic                       sda_oe_n;
  logic                       sda_drv;

  // decode of the synchronised lines
  logic                       scl_s;
  logic                       sda_s;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_seen;
  logic                       stop_seen;
  logic                       pwr_done;
  logic                       byte_full;
  logic                       id_match;
  logic                       addr_match;
  logic                       byte_ok;
  logic [7:0]                 first_tx;
  wpx_pkg::wpx_kind_t         next_kind;

  // only the second stage is looked at; the first may be metastable
  assign scl_s    = scl_sync[1];
  assign sda_s    = sda_sync[1];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;

  // a data edge while the clock stays high marks start or stop
  assign start_seen = ~sda_s & sda_q & scl_s & scl_q;
  assign stop_seen  = sda_s & ~sda_q & scl_s & scl_q;
  assign pwr_done   = (pwr_cnt == wpx_pkg::PWRUP_CYC);

  // byte checks, valid once eight bits have been clocked in
  assign byte_full  = (cnt == wpx_pkg::BYTE_BITS);
  assign id_match   = (rx_shift[7:1] == wpx_pkg::SLAVE_ID);
  assign addr_match = (rx_shift == wpx_pkg::WIPER_ADDR);

  // write data is always taken once the address was accepted
  assign byte_ok = (kind == wpx_pkg::kind_id)   ? id_match :
                   (kind == wpx_pkg::kind_addr) ? addr_match : 1'b1;

  // a read id leads straight to sending; a write id to the address byte
  assign next_kind = (kind == wpx_pkg::kind_id)   ?
                       (rx_shift[0] ? wpx_pkg::kind_send : wpx_pkg::kind_addr) :
                     (kind == wpx_pkg::kind_addr) ? wpx_pkg::kind_data :
                                                    wpx_pkg::kind_done;

  // readback always shows a zero in the top bit
  assign first_tx = {1'b0, wiper_position_o};

  // the pad is open drain: the driven level is always low
  assign bus.s_sda_o    = sda_drv;
  assign bus.s_sda_oe_n = sda_oe_n;

  // input synchronisers; lines idle high
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  // holdoff counter; reset is the power-up event, so it runs once
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_cnt <= 4'h0;
    end else if (!pwr_done) begin
      pwr_cnt <= pwr_cnt + 4'h1;
    end
  end

  // output data level never changes; only the enable moves
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_drv <= 1'b0;
    end else begin
      sda_drv <= 1'b0;
    end
  end

  // bus state machine; all bit timing follows the master's clock edges
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state            <= wpx_pkg::dev_idle;
      kind             <= wpx_pkg::kind_id;
      cnt              <= 4'h0;
      rx_shift         <= 8'h00;
      tx_shift         <= 8'h00;
      mack             <= 1'b0;
      sda_oe_n         <= 1'b1;
      wiper_position_o <= wpx_pkg::WIPER_RESET;
    end else if (start_seen && pwr_done) begin
      // a start, repeated or not, always restarts at the id byte
      state    <= wpx_pkg::dev_recv;
      kind     <= wpx_pkg::kind_id;
      cnt      <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_seen) begin
      state    <= wpx_pkg::dev_idle;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state)
        wpx_pkg::dev_idle: begin
          sda_oe_n <= 1'b1;
        end
        wpx_pkg::dev_recv: begin
          if (scl_rise && !byte_full) begin
            // sampled at the rising edge, first bit is the msb
            rx_shift <= {rx_shift[6:0], sda_s};
            cnt      <= cnt + 4'h1;
          end else if (scl_fall && byte_full) begin
            if (byte_ok) begin
              state    <= wpx_pkg::dev_ack;
              sda_oe_n <= 1'b0;
            end else begin
              state    <= wpx_pkg::dev_idle;
            end
            if (kind == wpx_pkg::kind_data) begin
              // loaded on the falling edge that ends the last data bit
              wiper_position_o <= rx_shift[6:0];
            end
            kind <= next_kind;
          end
        end
        wpx_pkg::dev_ack: begin
          // ack is held until the ninth clock falls
          if (scl_fall) begin
            cnt <= 4'h0;
            if (kind == wpx_pkg::kind_send) begin
              state    <= wpx_pkg::dev_send;
              tx_shift <= first_tx;
              sda_oe_n <= first_tx[7];
            end else if (kind == wpx_pkg::kind_done) begin
              state    <= wpx_pkg::dev_idle;
              sda_oe_n <= 1'b1;
            end else begin
              state    <= wpx_pkg::dev_recv;
              sda_oe_n <= 1'b1;
            end
          end
        end
        wpx_pkg::dev_send: begin
          // the next bit is put out just after each falling edge
          if (scl_fall) begin
            if (cnt == wpx_pkg::LAST_BIT) begin
              state    <= wpx_pkg::dev_mack;
              sda_oe_n <= 1'b1;
            end else begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe_n <= tx_shift[6];
              cnt      <= cnt + 4'h1;
            end
          end
        end
        wpx_pkg::dev_mack: begin
          if (scl_rise) begin
            mack <= ~sda_s;
          end else if (scl_fall) begin
            cnt <= 4'h0;
            if (mack) begin
              // the same byte is repeated for as long as it is acked
              state    <= wpx_pkg::dev_send;
              tx_shift <= first_tx;
              sda_oe_n <= first_tx[7];
            end else begin
              state    <= wpx_pkg::dev_idle;
              sda_oe_n <= 1'b1;
            end
          end
        end
        default: begin
          state    <= wpx_pkg::dev_idle;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // the wiper output is the register itself: code 0 is the tap at the
  // low terminal, all ones the tap at the high terminal, steps in order

endmodule : wpx_slave

// ===== verif/tb_top.sv
// self-checking bench: apb driven controller talking to the wiper slave
`timescale 1ns/1ps
module tb_top;
  // about 83,000 cycles of serial traffic are expected; a hang stops the run at 95,000, some 12,000 above that
  localparam int TMO = 95000;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  wiper;
  logic [79:0] notes[$];
  logic [79:0] note;
  logic [31:0] rdv;
  logic [7:0]  dat;
  logic [7:0]  vals[3] = '{8'h00, 8'h7f, 8'h80};
  logic [6:0]  id      = wpx_pkg::SLAVE_ID;
  int          error_cnt = 0;
  int          checked   = 0;
  int          cyc       = 0;
  int          seed      = 91;

  wpx_bus_if wpx_bus_if_i ();
  wpx_master wpx_master_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(wpx_bus_if_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  wpx_slave wpx_slave_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(wpx_bus_if_i),
    .wiper_position_o(wiper));
  wpx_link_sva wpx_link_sva_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .scl(wpx_bus_if_i.scl), .sda(wpx_bus_if_i.sda), .m_sda_oe_n(wpx_bus_if_i.m_sda_oe_n),
    .s_sda_oe_n(wpx_bus_if_i.s_sda_oe_n), .wiper_position_o(wiper));

  // 50 MHz reference clock
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_of_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; the note holds {mask, expected} of {wiper, pslverr, prdata}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [39:0] exp, input logic [39:0] msk);
    notes.push_back({msk, exp});
    @(posedge ref_clk_i);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1) @(posedge ref_clk_i);
    rdv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // start a bus transfer and poll status until the controller is idle again
  task automatic run(input logic rd, input logic [3:0] cnt, input logic [6:0] sid);
    apb(1'b1, wpx_pkg::REG_CMD, {17'h0, sid, cnt, 2'b00, rd, 1'b1}, 40'h0, 40'h1_0000_0000);
    rdv = 32'h1;
    while (rdv[0] !== 1'b0) apb(1'b0, wpx_pkg::REG_STAT, 32'h0, 40'h0, 40'h0);
  endtask : run

  // answers are judged on the edge where pready is seen, oldest note first
  always @(posedge ref_clk_i) begin
    if (pready === 1'b1) begin
      note = notes.pop_front();
      if (note[79:40] !== 40'h0) check({wiper, pslverr, prdata} & note[79:40], note[39:0]);
    end
  end

  // a hang ends the run as a failure
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == TMO) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, wpx_pkg::REG_STAT, 32'h0, {7'h40, 33'h0}, {7'h7f, 33'h1_0000_0003});
    apb(1'b0, 8'h0c, 32'h0, {7'h40, 1'b1, 32'h0}, 40'hff_ffff_ffff);
    // end values, then a random byte with its top bit set to show it is dropped
    foreach (vals[i]) begin
      dat = (i == 2) ? (vals[i] | 8'($random(seed))) : vals[i];
      apb(1'b1, wpx_pkg::REG_TXD, {16'h0, dat, wpx_pkg::WIPER_ADDR}, 40'h0, 40'h1_0000_0000);
      run(1'b0, 4'h0, id);
      apb(1'b0, wpx_pkg::REG_STAT, 32'h0, {dat[6:0], 33'h0}, {7'h7f, 33'h1_0000_0003});
    end
    // two-byte read back; top bit of the returned byte must be clear
    run(1'b1, 4'h2, id);
    apb(1'b0, wpx_pkg::REG_STAT, 32'h0, {dat[6:0], 18'h0, dat[6:0], 8'h0},
        {7'h7f, 1'b1, 16'h0, 16'hff03});
    // nonzero address is refused and the wiper keeps its value
    apb(1'b1, wpx_pkg::REG_TXD, 32'h1201, 40'h0, 40'h1_0000_0000);
    run(1'b0, 4'h0, id);
    apb(1'b0, wpx_pkg::REG_STAT, 32'h0, {dat[6:0], 33'h2}, {7'h7f, 33'h1_0000_0003});
    // wrong device code is refused as well
    apb(1'b1, wpx_pkg::REG_TXD, 32'h3300, 40'h0, 40'h1_0000_0000);
    run(1'b0, 4'h0, id ^ 7'h01);
    apb(1'b0, wpx_pkg::REG_STAT, 32'h0, {dat[6:0], 33'h2}, {7'h7f, 33'h1_0000_0003});
    // the controller keeps the last id it sent and the bytes it was given
    apb(1'b0, wpx_pkg::REG_CMD, 32'h0, {8'h00, 17'h0, id ^ 7'h01, 8'h00}, 40'h1_ffff_ffff);
    apb(1'b0, wpx_pkg::REG_TXD, 32'h0, 40'h0_0000_3300, 40'h1_ffff_ffff);
    // a second power-up puts the wiper back to midscale and releases the data line
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, wpx_pkg::REG_STAT, 32'h0, {7'h40, 33'h0}, {7'h7f, 33'h1_0000_0003});
    end_of_test();
  end
endmodule : tb_top

// ===== verif/wpx_link_sva.sv
// checker for the two-wire link between the controller and the wiper slave
`timescale 1ns/1ps
module wpx_link_sva (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       m_sda_oe_n,
  input wire logic       s_sda_oe_n,
  input wire logic [6:0] wiper_position_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // bus conditions need the clock line high over two samples
  sequence start_s; scl && $past(scl) && $fell(sda); endsequence
  sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
  // the slave drives low for an ack or a zero bit
  sequence drive_low_s; (!s_sda_oe_n && !scl) [*8]; endsequence

  pwrup_release_a: assert property ($rose(rst_n_i) |-> s_sda_oe_n [*8])
    else $error("slave drove data right after reset");
  wiper_preset_a: assert property ($rose(rst_n_i) |-> wiper_position_o == 7'h40)
    else $error("wiper not at midscale after reset");
  slave_edge_a: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("slave changed data while clock high");
  slave_hold_a: assert property ($fell(s_sda_oe_n) |-> drive_low_s)
    else $error("slave data not set up inside a low clock phase");
  wiper_load_a: assert property ($changed(wiper_position_o) |-> !scl)
    else $error("wiper loaded outside a low clock phase");
  start_listen_a: assert property (start_s |-> s_sda_oe_n [*8])
    else $error("slave drove data right after a start");
  stop_idle_a: assert property (stop_s |-> s_sda_oe_n [*8])
    else $error("slave drove data right after a stop");
  high_stable_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe_n))
    else $error("data moved during clock high without a master condition");
endmodule : wpx_link_sva
